// file: logic/core_timer_up_down.sv
// The placing of the registers and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ps
module core_timer_up_down (
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        gate_count_pin,
    input  wire logic        direction_pin,
    input  wire logic        port3_bit3,
    output logic             toggle_output_pin,
    output logic             toggle_latch,
    output logic             overflow_event
);

    typedef struct packed {
        logic [2:0]  gate_sync;
        logic [2:0]  dir_sync;
        logic        gate_level;
        logic        dir_level;
        logic [9:0]  prescale;
        logic [15:0] control;
        logic [15:0] count;
        logic        ack;
        logic [31:0] rdata;
        logic        pin_out;
        logic        latch_out;
        logic        flip;
    } state_t;

    state_t state_ff;
    state_t nxt_state;
    logic [1:0] rst_sync_ff;
    logic [1:0] nxt_rst_sync;

    logic rst_n;
    assign rst_n = rst_sync_ff[1];

    // tick when the low 3+sel prescaler bits are all ones
    function automatic logic tick_of(input logic [9:0] pre, input logic [2:0] sel);
        logic [10:0] mask;
        mask = 11'((11'h001 << (core_timer_pkg::PRESCALE_BASE_LOG2 + int'(sel))) - 11'h001);
        tick_of = ((pre & mask[9:0]) == mask[9:0]);
    endfunction

    // byte lane merge of a 16-bit register
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
        merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction

    logic [2:0] insel;
    logic [2:0] mode;
    logic       run;
    logic       down;
    logic       gate_ok;
    logic       edge_hit;
    logic       rise;
    logic       fall;
    logic       step;
    logic       wrap;
    logic       bus_req;
    logic       wr_ctl;
    logic       wr_cnt;

    always_comb begin
        nxt_state = state_ff;
        insel = state_ff.control[core_timer_pkg::POS_INSEL +: 3];
        mode  = state_ff.control[core_timer_pkg::POS_MODE +: 3];
        run   = state_ff.control[core_timer_pkg::POS_RUN];

        // three stage pin synchronisers, level changes once stages 2 and 3 agree
        nxt_state.gate_sync = {state_ff.gate_sync[1:0], gate_count_pin};
        nxt_state.dir_sync  = {state_ff.dir_sync[1:0], direction_pin};
        if (state_ff.gate_sync[2] == state_ff.gate_sync[1]) begin
            nxt_state.gate_level = state_ff.gate_sync[2];
        end
        if (state_ff.dir_sync[2] == state_ff.dir_sync[1]) begin
            nxt_state.dir_level = state_ff.dir_sync[2];
        end
        rise = nxt_state.gate_level & ~state_ff.gate_level;
        fall = ~nxt_state.gate_level & state_ff.gate_level;

        // direction: evaluated every cycle, independent of run
        if (state_ff.control[core_timer_pkg::POS_EXT_DIR_EN]) begin
            down = state_ff.dir_level ^ state_ff.control[core_timer_pkg::POS_SW_DIR];
        end else begin
            down = state_ff.control[core_timer_pkg::POS_SW_DIR];
        end

        // gate level; its changes only qualify counting, no event out
        gate_ok = state_ff.gate_level == mode[0];

        unique case (insel)
            core_timer_pkg::EDGE_RISE: edge_hit = rise;
            core_timer_pkg::EDGE_FALL: edge_hit = fall;
            core_timer_pkg::EDGE_ANY:  edge_hit = rise | fall;
            default:                   edge_hit = 1'b0;
        endcase

        nxt_state.prescale = 10'(state_ff.prescale + 10'h001);
        unique case (mode)
            core_timer_pkg::MODE_TIMER:
                step = run & tick_of(state_ff.prescale, insel);
            core_timer_pkg::MODE_COUNTER:
                step = run & edge_hit;
            core_timer_pkg::MODE_GATE_LOW, core_timer_pkg::MODE_GATE_HIGH:
                step = run & gate_ok & tick_of(state_ff.prescale, insel);
            default:
                step = 1'b0;
        endcase

        wrap = step & (down ? (state_ff.count == 16'h0000)
                            : (state_ff.count == 16'hFFFF));
        if (step) begin
            nxt_state.count = down ? 16'(state_ff.count - 16'h0001)
                                   : 16'(state_ff.count + 16'h0001);
        end
        nxt_state.flip = wrap;
        if (wrap) begin
            nxt_state.control[core_timer_pkg::POS_TOGGLE] =
                ~state_ff.control[core_timer_pkg::POS_TOGGLE];
        end

        // avalon slave: one wait cycle, answer on the second
        bus_req = (avs_read | avs_write) & ~state_ff.ack;
        wr_ctl  = bus_req & avs_write & (avs_address == core_timer_pkg::OFS_CONTROL);
        wr_cnt  = bus_req & avs_write & (avs_address == core_timer_pkg::OFS_COUNT);
        nxt_state.ack = bus_req;
        if (wr_ctl) begin
            nxt_state.control = merge(state_ff.control, avs_writedata, avs_byteenable)
                                & core_timer_pkg::CONTROL_MASK;
        end
        if (wr_cnt) begin
            nxt_state.count = merge(state_ff.count, avs_writedata, avs_byteenable);
        end
        unique case (avs_address)
            core_timer_pkg::OFS_CONTROL: nxt_state.rdata = {16'h0000, state_ff.control};
            core_timer_pkg::OFS_COUNT:   nxt_state.rdata = {16'h0000, state_ff.count};
            core_timer_pkg::OFS_STATUS:  nxt_state.rdata = {28'h0000000, state_ff.gate_level,
                                                            state_ff.dir_level, down, step};
            default:                     nxt_state.rdata = core_timer_pkg::UNMAPPED_READ;
        endcase

        // pin mux and internal latch feed use the updated latch
        nxt_state.latch_out = nxt_state.control[core_timer_pkg::POS_TOGGLE];
        nxt_state.pin_out = nxt_state.control[core_timer_pkg::POS_OUT_EN]
                          ? nxt_state.control[core_timer_pkg::POS_TOGGLE] : port3_bit3;
        nxt_rst_sync = {rst_sync_ff[0], 1'b1};
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= nxt_rst_sync;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff         <= '0;
            state_ff.control <= core_timer_pkg::CONTROL_RESET;
            state_ff.count   <= core_timer_pkg::COUNT_RESET;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign avs_readdata      = state_ff.rdata;
    assign avs_waitrequest   = ~state_ff.ack;
    assign toggle_output_pin = state_ff.pin_out;
    assign toggle_latch      = state_ff.latch_out;
    assign overflow_event    = state_ff.flip;

endmodule // core_timer_up_down

// file: logic/core_timer_pkg.sv
package core_timer_pkg;
    // register word offsets (byte addresses)
    localparam logic [3:0]  OFS_CONTROL    = 4'h0;
    localparam logic [3:0]  OFS_COUNT      = 4'h4;
    localparam logic [3:0]  OFS_STATUS     = 4'h8;
    // control field positions
    localparam int          POS_INSEL      = 0;
    localparam int          POS_MODE       = 3;
    localparam int          POS_GATE_POL   = 3;
    localparam int          POS_RUN        = 6;
    localparam int          POS_SW_DIR     = 7;
    localparam int          POS_EXT_DIR_EN = 8;
    localparam int          POS_OUT_EN     = 9;
    localparam int          POS_TOGGLE     = 10;
    localparam logic [15:0] CONTROL_RESET  = 16'h0000;
    localparam logic [15:0] COUNT_RESET    = 16'h0000;
    localparam logic [15:0] CONTROL_MASK   = 16'h07FF;
    // modes
    localparam logic [2:0]  MODE_TIMER     = 3'h0;
    localparam logic [2:0]  MODE_COUNTER   = 3'h1;
    localparam logic [2:0]  MODE_GATE_LOW  = 3'h2;
    localparam logic [2:0]  MODE_GATE_HIGH = 3'h3;
    // counter edge selection
    localparam logic [2:0]  EDGE_NONE      = 3'h0;
    localparam logic [2:0]  EDGE_RISE      = 3'h1;
    localparam logic [2:0]  EDGE_FALL      = 3'h2;
    localparam logic [2:0]  EDGE_ANY       = 3'h3;
    // prescaler base division 8, max 1024
    localparam int          PRESCALE_BASE_LOG2 = 3;
    localparam int          PRESCALE_WIDTH     = 10;
    localparam logic [31:0] UNMAPPED_READ  = 32'h00000000;
endpackage

// file: test/core_timer_pins.sv
`timescale 1ns/1ps
module core_timer_pins (
    input  wire logic core_clk,
    input  wire logic gate_req,
    input  wire logic dir_req,
    output logic      gate_count_pin,
    output logic      direction_pin
);
    logic [3:0] held_ff = 4'h0;
    initial gate_count_pin = 1'b1;
    initial direction_pin = 1'b0;
    // gate pin: new level only once the old one stood 9 clocks; direction pin follows dir_req every clock
    always @(posedge core_clk) begin
        direction_pin <= dir_req;
        if (gate_req != gate_count_pin && held_ff >= 4'h8) begin
            gate_count_pin <= gate_req;
            held_ff <= 4'h0;
        end else if (held_ff < 4'h8) begin
            held_ff <= held_ff + 4'h1;
        end
    end
endmodule // core_timer_pins

// file: test/core_timer_up_down_asserts.sv
`timescale 1ns/1ps
module core_timer_up_down_asserts (
    input wire logic        core_clk,
    input wire logic        resetn,
    input wire logic [3:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        port3_bit3,
    input wire logic        toggle_output_pin,
    input wire logic        toggle_latch,
    input wire logic        overflow_event
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    wire req = avs_read | avs_write;
    a_answer_short: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("answer too long");
    a_answer_bound: assert property (req && avs_waitrequest |-> ##[0:2] !avs_waitrequest)
        else $error("no answer");
    a_answer_cause: assert property (!avs_waitrequest |-> $past(req))
        else $error("answer unasked");
    a_upper_zero: assert property (
        avs_read && !avs_waitrequest |-> avs_readdata[31:16] == 16'h0000)
        else $error("upper bits set");
    a_unmapped_zero: assert property (
        avs_read && !avs_waitrequest && avs_address == 4'hC |-> avs_readdata == 32'h00000000)
        else $error("unmapped read");
    a_event_pulse: assert property (overflow_event |=> !overflow_event [*6])
        else $error("events too close");
    a_latch_cause: assert property ($changed(toggle_latch) |->
        overflow_event || $past(overflow_event) || $past(avs_write) || $past(avs_write, 2))
        else $error("latch moved");
    a_pin_source: assert property (
        toggle_output_pin == toggle_latch || toggle_output_pin == $past(port3_bit3))
        else $error("pin source");
    cover property (overflow_event);
    cover property (avs_write && !avs_waitrequest);
    cover property (avs_read && !avs_waitrequest && avs_address == 4'h4);
endmodule // core_timer_up_down_asserts
bind core_timer_up_down core_timer_up_down_asserts i_asserts (.core_clk, .resetn, .avs_address,
    .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .port3_bit3, .toggle_output_pin,
    .toggle_latch, .overflow_event);

// file: test/tb_core_timer_up_down.sv
`timescale 1ns/1ps
module tb_core_timer_up_down;
    logic core_clk = 1'b0, resetn = 1'b0, avs_read = 1'b0, avs_write = 1'b0, port3_bit3 = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    logic avs_waitrequest, gate_count_pin, direction_pin, toggle_output_pin, toggle_latch;
    logic overflow_event, gate_req = 1'b1, dir_req = 1'b0, seen;
    int mismatches = 0, tests_run = 0, cycles = 0;
    localparam logic [15:0] RC [6] = '{16'h0040, 16'h0047, 16'h0000, 16'h0050, 16'h0058,
        16'h0060};
    localparam int RN [6] = '{160, 20480, 200, 200, 160, 200};
    localparam logic [15:0] CC [7] = '{16'h0048, 16'h0049, 16'h004A, 16'h004B, 16'h014B,
        16'h01CB, 16'h00CB};
    localparam logic [15:0] CE [7] = '{16'h0000, 16'h0002, 16'h0002, 16'h0004, 16'hFFFC,
        16'h0004, 16'hFFFC};
    always #20 core_clk = ~core_clk;
    core_timer_up_down i_dut (.core_clk, .resetn, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable(4'h3), .avs_readdata, .avs_waitrequest, .gate_count_pin,
        .direction_pin, .port3_bit3, .toggle_output_pin, .toggle_latch, .overflow_event);
    core_timer_pins i_pins (.core_clk, .gate_req, .dir_req, .gate_count_pin, .direction_pin);
    task automatic tally_and_finish();
        if (mismatches == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            mismatches++;
            tally_and_finish();
        end
    end
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        {avs_write, avs_read, avs_address, avs_writedata} <= {w, !w, a, d};
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        {avs_write, avs_read} <= 2'b00;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    initial begin
        repeat (16) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge core_clk);
        bus(0, 4'h0, 0); chk(q, 0);
        bus(0, 4'hC, 0); chk(q, 0);
        bus(1, 4'h4, 32'hA5C3); bus(0, 4'h4, 0); chk(q, 32'hA5C3);
        for (int i = 0; i < 6; i++) begin
            bus(1, 4'h4, 0);
            bus(1, 4'h0, {16'h0, RC[i]});
            repeat (RN[i]) @(posedge core_clk);
            bus(1, 4'h0, 0);
            bus(0, 4'h4, 0);
            chk({31'h0, q <= 21 && q >= (RN[i] == 200 ? 0 : 19)}, 1);
        end
        bus(1, 4'h4, 0);
        bus(1, 4'h0, 32'h00C0);
        seen = 1'b0;
        repeat (40) @(posedge core_clk) seen |= (overflow_event === 1'b1);
        chk({seen, toggle_latch}, 2'b11);
        bus(0, 4'h4, 0); chk(q[15:8], 8'hFF);
        for (int i = 0; i < 3; i++) begin
            bus(1, 4'h0, {21'h0, i[1:0] + 2'h1, 9'h0});
            repeat (3) @(posedge core_clk);
            chk({toggle_latch, toggle_output_pin}, {i != 0, i == 2});
        end
        for (int i = 0; i < 7; i++) begin
            bus(1, 4'h4, 0);
            dir_req <= (i == 4 || i == 5);
            bus(1, 4'h0, {16'h0, CC[i]});
            repeat (4) begin
                gate_req <= !gate_req;
                repeat (14) @(posedge core_clk);
            end
            bus(0, 4'h4, 0); chk(q, {16'h0, CE[i]});
        end
        bus(0, 4'h8, 0); chk(q, 32'h0000000A);
        tally_and_finish();
    end
endmodule // tb_core_timer_up_down
